// File: cell_input_pkg.sv
// Package with register map, field layout and types for the cell input selection front end.
package cell_input_pkg;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses on the APB bus)
   // ----------------------------------------------------------------
   localparam logic [7:0] SELECT_REG_A_OFFSET = 8'h00;
   localparam logic [7:0] SELECT_REG_B_OFFSET = 8'h04;
   localparam logic [7:0] CELL_STATUS_OFFSET  = 8'h08;

   // ----------------------------------------------------------------
   // Field positions inside the select registers
   // ----------------------------------------------------------------
   localparam int LOW_CODE_LSB  = 0;
   localparam int HIGH_CODE_LSB = 4;
   localparam int CODE_WIDTH    = 3;

   // Low-index candidate of each multiplexer.
   localparam int MUX1_BASE = 0;
   localparam int MUX2_BASE = 4;
   localparam int MUX3_BASE = 8;
   localparam int MUX4_BASE = 12;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] SELECT_RESET = 32'h0000_0000;
   localparam logic [31:0] READ_ZERO    = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef logic [2:0] select_code_t;

   // Candidate signals that are common to every cell.
   typedef struct packed {
      logic [3:0] cell_outputs;
      logic       timer2_period_match;
      logic       timer1_wrap_event;
      logic       timer0_wrap_event;
      logic       system_clock;
      logic       comparator2_synced;
      logic       comparator1_synced;
      logic       cell_pin_input_1;
      logic       cell_pin_input_0;
   } common_candidates_t;

   // Four selected data lines towards the gating stage.
   typedef struct packed {
      logic selected_line_4;
      logic selected_line_3;
      logic selected_line_2;
      logic selected_line_1;
   } selected_lines_t;

   // APB request from the master.
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } apb_req_t;

endpackage : cell_input_pkg

// File: cell_input_select.sv
// Input selection front end of one configurable logic cell with its APB select registers.
//
// The register addresses and register access over APB were left to the implementer.

module cell_input_select
   import cell_input_pkg::*;
#(
   parameter int NUM_CANDIDATES = 16,
   parameter int NUM_MUXES      = 4
)
(
   input  wire logic                            pclk,
   input  wire logic                            presetn,
   input  wire cell_input_pkg::apb_req_t        apb_req,
   output logic [31:0]                          prdata,
   output logic                                 pready,
   output logic                                 pslverr,
   input  wire cell_input_pkg::common_candidates_t common_in,
   input  wire logic [3:0]                      cell_specific_in,
   output cell_input_pkg::selected_lines_t      gate_lines_1,
   output cell_input_pkg::selected_lines_t      gate_lines_2,
   output cell_input_pkg::selected_lines_t      gate_lines_3,
   output cell_input_pkg::selected_lines_t      gate_lines_4
);
   import cell_input_pkg::*;

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   if (NUM_CANDIDATES != 16 || NUM_MUXES != 4)
   begin : g_bad_size
      $error("cell_input_select supports 16 candidates and 4 multiplexers only");
   end

   // ----------------------------------------------------------------
   // Candidate vector
   // ----------------------------------------------------------------
   logic [15:0]     candidate_input;
   select_code_t    mux1_select_code;
   select_code_t    mux2_select_code;
   select_code_t    mux3_select_code;
   select_code_t    mux4_select_code;
   logic [7:0]      input_select_reg_a_q;
   logic [7:0]      input_select_reg_b_q;
   selected_lines_t lines_d;
   selected_lines_t lines_q;
   logic            wr_en;
   logic            rd_en;
   logic            addr_ok;
   logic            setup_phase;
   logic [31:0]     rd_word_d;
   logic [7:0]      mux1_window;
   logic [7:0]      mux2_window;
   logic [7:0]      mux3_window;
   logic [7:0]      mux4_window;
   logic            pick_1;
   logic            pick_2;
   logic            pick_3;
   logic            pick_4;

   // Common candidates fill 0-11, cell-specific sources fill 12-15.
   assign candidate_input = {cell_specific_in, common_in};

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   assign wr_en   = apb_req.psel && apb_req.penable && apb_req.pwrite;
   assign rd_en   = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
   assign setup_phase = apb_req.psel && !apb_req.penable;
   assign addr_ok = (apb_req.paddr == SELECT_REG_A_OFFSET) ||
                    (apb_req.paddr == SELECT_REG_B_OFFSET) ||
                    (apb_req.paddr == CELL_STATUS_OFFSET);

   // Select register A; reset value is a convenience, software must still program it.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         input_select_reg_a_q <= SELECT_RESET[7:0];
      end
      else if (wr_en && apb_req.paddr == SELECT_REG_A_OFFSET)
      begin
         input_select_reg_a_q <= {1'b0, apb_req.pwdata[HIGH_CODE_LSB +: CODE_WIDTH],
                                  1'b0, apb_req.pwdata[LOW_CODE_LSB +: CODE_WIDTH]};
      end
   end

   // Select register B.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         input_select_reg_b_q <= SELECT_RESET[7:0];
      end
      else if (wr_en && apb_req.paddr == SELECT_REG_B_OFFSET)
      begin
         input_select_reg_b_q <= {1'b0, apb_req.pwdata[HIGH_CODE_LSB +: CODE_WIDTH],
                                  1'b0, apb_req.pwdata[LOW_CODE_LSB +: CODE_WIDTH]};
      end
   end

   // Read word is chosen from the addressed register; unmapped addresses read zero.
   always_comb
   begin
      rd_word_d = READ_ZERO;
      case (apb_req.paddr)
         SELECT_REG_A_OFFSET:
         begin
            rd_word_d = {24'h00_0000, input_select_reg_a_q};
         end
         SELECT_REG_B_OFFSET:
         begin
            rd_word_d = {24'h00_0000, input_select_reg_b_q};
         end
         CELL_STATUS_OFFSET:
         begin
            rd_word_d = {28'h000_0000, lines_q};
         end
         default:
         begin
            rd_word_d = READ_ZERO;
         end
      endcase
   end

   // Read data is captured in the setup cycle so the access phase completes at once.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= READ_ZERO;
      end
      else if (rd_en)
      begin
         prdata <= rd_word_d;
      end
   end

   // The answer pulses for one cycle, in the access phase after every setup cycle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
      end
      else
      begin
         pready <= setup_phase;
      end
   end

   // An unmapped address is flagged together with the answer.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pslverr <= 1'b0;
      end
      else
      begin
         pslverr <= setup_phase && !addr_ok;
      end
   end

   // ----------------------------------------------------------------
   // Multiplexers
   // ----------------------------------------------------------------
   assign mux1_select_code = input_select_reg_a_q[LOW_CODE_LSB +: CODE_WIDTH];
   assign mux2_select_code = input_select_reg_a_q[HIGH_CODE_LSB +: CODE_WIDTH];
   assign mux3_select_code = input_select_reg_b_q[LOW_CODE_LSB +: CODE_WIDTH];
   assign mux4_select_code = input_select_reg_b_q[HIGH_CODE_LSB +: CODE_WIDTH];

   // Each multiplexer sees an eight-wide window; the fourth wraps from 15 back to 0.
   assign mux1_window = candidate_input[MUX1_BASE +: 8];
   assign mux2_window = candidate_input[MUX2_BASE +: 8];
   assign mux3_window = candidate_input[MUX3_BASE +: 8];
   assign mux4_window = {candidate_input[3:0], candidate_input[MUX4_BASE +: 4]};

   // Multiplexer one walks candidates 0 to 7.
   cand_mux #(
      .CODE_W (CODE_WIDTH),
      .WIDTH  (1 << CODE_WIDTH)
   )
   u_mux1 (
      .window (mux1_window),
      .code   (mux1_select_code),
      .picked (pick_1)
   );

   // Multiplexer two walks candidates 4 to 11.
   cand_mux #(
      .CODE_W (CODE_WIDTH),
      .WIDTH  (1 << CODE_WIDTH)
   )
   u_mux2 (
      .window (mux2_window),
      .code   (mux2_select_code),
      .picked (pick_2)
   );

   // Multiplexer three walks candidates 8 to 15.
   cand_mux #(
      .CODE_W (CODE_WIDTH),
      .WIDTH  (1 << CODE_WIDTH)
   )
   u_mux3 (
      .window (mux3_window),
      .code   (mux3_select_code),
      .picked (pick_3)
   );

   // Multiplexer four walks candidates 12 to 15 and then 0 to 3.
   cand_mux #(
      .CODE_W (CODE_WIDTH),
      .WIDTH  (1 << CODE_WIDTH)
   )
   u_mux4 (
      .window (mux4_window),
      .code   (mux4_select_code),
      .picked (pick_4)
   );

   // The four picks form the word handed to the gating stage.
   always_comb
   begin
      lines_d.selected_line_1 = pick_1;
      lines_d.selected_line_2 = pick_2;
      lines_d.selected_line_3 = pick_3;
      lines_d.selected_line_4 = pick_4;
   end

   // ----------------------------------------------------------------
   // Registered lines; the same word fans out to all four gates
   // ----------------------------------------------------------------
   // Status copy of the selected lines for software reads.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lines_q <= '0;
      end
      else
      begin
         lines_q <= lines_d;
      end
   end

   // Lines towards gate one.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gate_lines_1 <= '0;
      end
      else
      begin
         gate_lines_1 <= lines_d;
      end
   end

   // Lines towards gate two.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gate_lines_2 <= '0;
      end
      else
      begin
         gate_lines_2 <= lines_d;
      end
   end

   // Lines towards gate three.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gate_lines_3 <= '0;
      end
      else
      begin
         gate_lines_3 <= lines_d;
      end
   end

   // Lines towards gate four.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gate_lines_4 <= '0;
      end
      else
      begin
         gate_lines_4 <= lines_d;
      end
   end

endmodule // cell_input_select

// ----------------------------------------------------------------
// One eight-way multiplexer of the selection stage
// ----------------------------------------------------------------
module cand_mux
#(
   parameter int CODE_W = 3,
   parameter int WIDTH  = 8
)
(
   input  wire logic [WIDTH-1:0]  window,
   input  wire logic [CODE_W-1:0] code,
   output logic                   picked
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   // Every code must name exactly one input of the window.
   if (WIDTH != (1 << CODE_W))
   begin : g_bad_width
      $error("cand_mux needs a window of two to the power of the code width");
   end

   // ----------------------------------------------------------------
   // Selection
   // ----------------------------------------------------------------
   // The code indexes the window; every other input is shut out.
   always_comb
   begin
      picked = window[code];
   end

endmodule // cand_mux

// File: cell_input_chk.sv
// Checker of select routing and register answers of the cell input front end.
module cell_input_chk
   import cell_input_pkg::*;
(
   input wire logic                               pclk,
   input wire logic                               presetn,
   input wire cell_input_pkg::apb_req_t           apb_req,
   input wire logic [31:0]                        prdata,
   input wire logic                               pready,
   input wire logic                               pslverr,
   input wire cell_input_pkg::common_candidates_t common_in,
   input wire logic [3:0]                         cell_specific_in,
   input wire cell_input_pkg::selected_lines_t    gate_lines_1,
   input wire cell_input_pkg::selected_lines_t    gate_lines_2,
   input wire cell_input_pkg::selected_lines_t    gate_lines_3,
   input wire cell_input_pkg::selected_lines_t    gate_lines_4
);
   logic [15:0] cand;
   logic [5:0]  a_q;
   logic [5:0]  b_q;
   logic [3:0]  exp_q;
   logic        setup;
   logic        wr;

   // Candidate bus and request phases.
   assign cand  = {cell_specific_in, common_in};
   assign setup = apb_req.psel & ~apb_req.penable;
   assign wr    = apb_req.psel & apb_req.penable & pready & apb_req.pwrite;

   // Shadow codes follow every completed write.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         a_q <= 6'h00;
         b_q <= 6'h00;
      end
      else if (wr && apb_req.paddr == SELECT_REG_A_OFFSET)
         a_q <= {apb_req.pwdata[6:4], apb_req.pwdata[2:0]};
      else if (wr && apb_req.paddr == SELECT_REG_B_OFFSET)
         b_q <= {apb_req.pwdata[6:4], apb_req.pwdata[2:0]};
   end

   // Expected lines lag the candidates by one clock.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         exp_q <= 4'h0;
      else
         exp_q <= {cand[4'(12 + b_q[5:3])], cand[4'(8 + b_q[2:0])], cand[4'(4 + a_q[5:3])], cand[4'(a_q[2:0])]};
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_ANSWER: assert property (setup |=> pready) else $error("no answer after setup");
   AST_PULSE: assert property (pready |=> !pready) else $error("answer held too long");
   AST_SAME: assert property (gate_lines_1 == gate_lines_2 && gate_lines_1 == gate_lines_3
      && gate_lines_1 == gate_lines_4) else $error("gate copies differ");
   AST_LINE1: assert property (gate_lines_1.selected_line_1 == exp_q[0]) else $error("line 1 wrong");
   AST_LINE2: assert property (gate_lines_1.selected_line_2 == exp_q[1]) else $error("line 2 wrong");
   AST_LINE3: assert property (gate_lines_1.selected_line_3 == exp_q[2]) else $error("line 3 wrong");
   AST_LINE4: assert property (gate_lines_1.selected_line_4 == exp_q[3]) else $error("line 4 wrong");
   AST_READ_A: assert property (setup && !apb_req.pwrite && apb_req.paddr == SELECT_REG_A_OFFSET
      |=> prdata == 32'({a_q[5:3], 1'b0, a_q[2:0]})) else $error("reg a read wrong");
   AST_UNMAPPED: assert property (setup && apb_req.paddr > CELL_STATUS_OFFSET |=> pslverr)
      else $error("no error answer");
endmodule // cell_input_chk

// File: cand_src.sv
// Model of the pins and peripherals that feed the candidate inputs.
module cand_src
   import cell_input_pkg::*;
(
   input wire logic [15:0]                   pattern,
   output cell_input_pkg::common_candidates_t common_in,
   output logic [3:0]                        cell_specific_in
);
   // Shared sources sit on candidates 0-11, cell sources on 12-15.
   assign common_in        = common_candidates_t'(pattern[11:0]);
   assign cell_specific_in = pattern[15:12];
endmodule // cand_src

// File: tb.sv
// Testbench of the cell input front end.
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import cell_input_pkg::*;
   logic pclk = 1'b0, presetn, pready, pslverr;
   apb_req_t req;
   logic [31:0] prdata;
   common_candidates_t common_in;
   logic [3:0] cell_specific_in;
   selected_lines_t gl1, gl2, gl3, gl4;
   logic [15:0] pattern;
   int n_errors = 0, n_compared = 0, cycles = 0;

   cand_src u_src (.pattern(pattern), .common_in(common_in), .cell_specific_in(cell_specific_in));
   cell_input_select u_dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .common_in(common_in), .cell_specific_in(cell_specific_in),
      .gate_lines_1(gl1), .gate_lines_2(gl2), .gate_lines_3(gl3), .gate_lines_4(gl4));

   // Clock and hang guard.
   initial forever #25 pclk = ~pclk;
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_errors++;
         print_verdict();
      end
   end

   task print_verdict;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task check(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One APB transfer; the answer is taken at the edge that sees pready.
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd, output logic err);
      @(posedge pclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
      @(posedge pclk);
      req.penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      req <= '0;
   endtask

   task test_regs;
      logic [31:0] d;
      logic e;
      apb(1'b0, SELECT_REG_A_OFFSET, 32'h0000_0000, d, e);
      check("reset a", SELECT_RESET, d);
      apb(1'b1, SELECT_REG_A_OFFSET, 32'hFFFF_FFFF, d, e);
      apb(1'b1, SELECT_REG_B_OFFSET, 32'h0000_0035, d, e);
      apb(1'b0, SELECT_REG_A_OFFSET, 32'h0000_0000, d, e);
      check("reg a", 32'h0000_0077, d);
      apb(1'b0, SELECT_REG_B_OFFSET, 32'h0000_0000, d, e);
      check("reg b", 32'h0000_0035, d);
      apb(1'b0, 8'h0C, 32'h0000_0000, d, e);
      check("unmapped", {READ_ZERO[31:1], 1'b1}, {d[31:1], e});
   endtask

   // Every code of every mux against a walking one on the candidates.
   task test_mux;
      logic [31:0] d;
      logic e;
      logic [3:0] ex;
      for (int c = 0; c < 8; c++)
      begin
         apb(1'b1, SELECT_REG_A_OFFSET, 32'((7 - c) * 16 + c), d, e);
         apb(1'b1, SELECT_REG_B_OFFSET, 32'(((c + 5) % 8) * 16 + (c + 3) % 8), d, e);
         for (int i = 0; i < 16; i++)
         begin
            pattern <= 16'(1 << i);
            @(posedge pclk);
            @(posedge pclk);
            ex = {i == (MUX4_BASE + (c + 5) % 8) % 16, i == MUX3_BASE + (c + 3) % 8, i == MUX2_BASE + 7 - c, i == c};
            check("lines", {4{ex}}, {gl4, gl3, gl2, gl1});
         end
         apb(1'b0, CELL_STATUS_OFFSET, 32'h0000_0000, d, e);
         check("status", {28'h000_0000, ex}, d);
         check("status err", 32'h0000_0000, {31'h0000_0000, e});
      end
   endtask

   initial
   begin
      presetn = 1'b0;
      req = '0;
      pattern = 16'h0000;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      test_regs();
      test_mux();
      print_verdict();
   end
endmodule // tb

bind cell_input_select cell_input_chk u_chk (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .common_in(common_in), .cell_specific_in(cell_specific_in),
   .gate_lines_1(gate_lines_1), .gate_lines_2(gate_lines_2), .gate_lines_3(gate_lines_3), .gate_lines_4(gate_lines_4));
